// ==== rtl/tamio_cfg.svh ====
`ifndef TAMIO_CFG_SVH
`define TAMIO_CFG_SVH

// Register byte offsets on the APB slave, one aligned 32-bit word each.
`define TAMIO_OFF_REVISION   12'h000
`define TAMIO_OFF_ENC_AZ     12'h004
`define TAMIO_OFF_ENC_PI     12'h008
`define TAMIO_OFF_CLEAR      12'h00c
`define TAMIO_OFF_CTRL_AZ    12'h010
`define TAMIO_OFF_CTRL_PI    12'h014
`define TAMIO_OFF_DIVIDER    12'h018
`define TAMIO_OFF_OVERHEAT   12'h01c
`define TAMIO_OFF_CUTOFF     12'h020
`define TAMIO_OFF_TACHO_AZ   12'h024
`define TAMIO_OFF_TACHO_PI   12'h028
`define TAMIO_OFF_BRAKE      12'h02c

// Field positions inside the shared divider word.
`define TAMIO_DIV_AZ_LSB     0
`define TAMIO_DIV_PI_LSB     8

// Reset values of the software-written fields.
`define TAMIO_RST_CLEAR      2'h0
`define TAMIO_RST_CUTOFF     2'h3
`define TAMIO_RST_BRAKE      2'h0
`define TAMIO_RST_CTRL       11'h000
`define TAMIO_RST_DIV        6'h00

// Clock rates in MHz; the base tick divider is derived from them.
`define TAMIO_CLK_MHZ        200
`define TAMIO_BASE_MHZ       40
`define TAMIO_BASE_DIV       (`TAMIO_CLK_MHZ / `TAMIO_BASE_MHZ)

// PWM period in prescaled base ticks and widest prescaler value.
`define TAMIO_PWM_PERIOD     1023
`define TAMIO_DIV_MAX        63

`endif

// ==== rtl/tamio_pkg.sv ====
package tamio_pkg;

    // Control word: signed, magnitude is the duty in prescaled base ticks.
    typedef logic signed [10:0] tamio_ctrl_t;
    typedef logic        [5:0]  tamio_div_t;
    typedef logic signed [15:0] tamio_count_t;
    typedef logic        [11:0] tamio_tacho_t;

    // Quadrature counter state.
    typedef struct packed {
        logic         aPrev;
        logic         bPrev;
        tamio_count_t count;
    } tamio_quad_t;

    // PWM channel state.
    typedef struct packed {
        tamio_div_t  presCnt;
        logic [9:0]  periodCnt;
        logic        pwm;
        logic        dir;
    } tamio_pwm_t;

    // Register file and bus state of the top level.
    typedef struct packed {
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic [1:0]    clearFlags;
        tamio_ctrl_t   ctrlAz;
        tamio_ctrl_t   ctrlPi;
        tamio_div_t    divAz;
        tamio_div_t    divPi;
        logic [1:0]    cutoffEn;
        logic [1:0]    brake;
        logic [1:0]    overheat;
        tamio_tacho_t  tachoAz;
        tamio_tacho_t  tachoPi;
        logic [2:0]    baseDiv;
        logic          baseTick;
    } tamio_regs_t;

endpackage : tamio_pkg

// ==== rtl/tamio_quad_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module tamio_quad_counter (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Encoder phases and clear level.
    input  wire logic                   phaseA,
    input  wire logic                   phaseB,
    input  wire logic                   clear,
    // Position count.
    output var  tamio_pkg::tamio_count_t count
);
    import tamio_pkg::*;

    tamio_quad_t s_r;
    tamio_quad_t s_nxt;
    logic [1:0]  prevAb;
    logic [1:0]  curAb;

    // Four-edge decode; one phase leading the other sets the direction.
    always_comb begin
        s_nxt       = s_r;
        prevAb      = {s_r.aPrev, s_r.bPrev};
        curAb       = {phaseA, phaseB};
        s_nxt.aPrev = phaseA;
        s_nxt.bPrev = phaseB;
        if (clear) begin
            s_nxt.count = '0;
        end else begin
            unique case ({prevAb, curAb})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: s_nxt.count = s_r.count + 16'sh0001;
                4'b0010, 4'b1011, 4'b1101, 4'b0100: s_nxt.count = s_r.count - 16'sh0001;
                default: s_nxt.count = s_r.count; // No step, or an illegal double jump.
            endcase
        end
    end

    // Counting wraps at the 16-bit limits by plain two's-complement overflow.
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.count;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // A moving count changes by one at most per clock; only a clear may jump it.
    a_count_single_step: assert property (
        ##1 $past(clear) || (s_r.count == $past(s_r.count))
            || (s_r.count == $past(s_r.count) + 16'sh0001)
            || (s_r.count == $past(s_r.count) - 16'sh0001))
        else $error("Encoder count jumped by more than one.");

    // A held clear keeps the count at zero.
    a_clear_keeps_zero: assert property (
        clear |=> s_r.count == 16'sh0000)
        else $error("Encoder count not zero while cleared.");
endmodule : tamio_quad_counter
`default_nettype wire

// ==== rtl/tamio_pwm_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tamio_cfg.svh"
module tamio_pwm_channel #(
    parameter int PERIOD = `TAMIO_PWM_PERIOD
) (
    // Clock, reset and 40 MHz base tick.
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  baseTick,
    // Settings and cutoff.
    input  wire tamio_pkg::tamio_ctrl_t ctrl,
    input  wire tamio_pkg::tamio_div_t  divider,
    input  wire logic                  suppress,
    // Drive outputs.
    output var  logic                  pwm,
    output var  logic                  dir
);
    import tamio_pkg::*;

    if (PERIOD < 2 || PERIOD > 1023) begin : g_bad_period
        $error("PWM period must lie in 2..1023.");
    end

    tamio_pwm_t s_r;
    tamio_pwm_t s_nxt;
    logic [11:0] mag;

    // Period counter advances once per (divider+1) base ticks.
    always_comb begin
        s_nxt = s_r;
        mag   = ctrl[10] ? 12'(-$signed({ctrl[10], ctrl})) : {1'b0, ctrl};
        if (mag > 12'(PERIOD)) begin
            mag = 12'(PERIOD); // Full negative is one step longer; clip it to full.
        end
        if (baseTick) begin
            if (s_r.presCnt >= divider) begin
                s_nxt.presCnt = '0;
                if (s_r.periodCnt >= 10'(PERIOD - 1)) begin
                    s_nxt.periodCnt = '0;
                end else begin
                    s_nxt.periodCnt = s_r.periodCnt + 10'h001;
                end
            end else begin
                s_nxt.presCnt = s_r.presCnt + 6'h01;
            end
        end
        // Zero magnitude never exceeds the count, so the wave stays low.
        s_nxt.pwm = ({2'b00, s_r.periodCnt} < mag) && !suppress;
        s_nxt.dir = ctrl[10];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pwm = s_r.pwm;
    assign dir = s_r.dir;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Direction follows the sign of the control value.
    a_dir_from_sign: assert property (
        $stable(ctrl) [*2] |-> dir == ctrl[10])
        else $error("Direction does not follow control sign.");

    // Full positive control with no cutoff keeps the wave high.
    a_full_duty_high: assert property (
        (ctrl == 11'sh3ff && !suppress) [*2] |-> pwm)
        else $error("Full control did not hold the wave high.");

    // Suppression forces the wave low on the next edge.
    a_cutoff_low: assert property (
        suppress |=> !pwm)
        else $error("Wave driven while cut off.");
endmodule : tamio_pwm_channel
`default_nettype wire

// ==== rtl/tamio_top.sv ====
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tamio_cfg.svh"
module tamio_top #(
    parameter logic [15:0] LOGIC_REVISION = 16'h0a01, // Arbitrary value.
    parameter int          PWM_PERIOD     = `TAMIO_PWM_PERIOD
) (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   reset,
    // APB slave.
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    // Encoder phases.
    input  wire logic                   encAzA,
    input  wire logic                   encAzB,
    input  wire logic                   encPiA,
    input  wire logic                   encPiB,
    // Amplifier overheat levels, azimuth in bit 0.
    input  wire logic [1:0]             overheatIn,
    // Tachogenerator converter results.
    input  wire tamio_pkg::tamio_tacho_t tachoAzIn,
    input  wire tamio_pkg::tamio_tacho_t tachoPiIn,
    input  wire logic                   tachoValid,
    // Motor power interface.
    output var  logic                   pwmAz,
    output var  logic                   dirAz,
    output var  logic                   brakeAz,
    output var  logic                   pwmPi,
    output var  logic                   dirPi,
    output var  logic                   brakePi
);
    import tamio_pkg::*;

    if (`TAMIO_BASE_DIV < 2 || `TAMIO_BASE_DIV > 8) begin : g_bad_base
        $error("Base tick divider must lie in 2..8.");
    end

    tamio_regs_t  r_r;
    tamio_regs_t  r_nxt;
    tamio_count_t encAz;
    tamio_count_t encPi;
    logic         accessPh;
    logic         doWrite;
    logic         mapped;
    logic [31:0]  readWord;

    // Azimuth encoder counter with its own clear bit.
    tamio_quad_counter u_enc_az (
        .clk    (clk),
        .reset  (reset),
        .phaseA (encAzA),
        .phaseB (encAzB),
        .clear  (r_r.clearFlags[0]),
        .count  (encAz)
    );

    // Pitch encoder counter with its own clear bit.
    tamio_quad_counter u_enc_pi (
        .clk    (clk),
        .reset  (reset),
        .phaseA (encPiA),
        .phaseB (encPiB),
        .clear  (r_r.clearFlags[1]),
        .count  (encPi)
    );

    // Azimuth drive, using the first prescaler field.
    tamio_pwm_channel #(
        .PERIOD (PWM_PERIOD)
    ) u_pwm_az (
        .clk      (clk),
        .reset    (reset),
        .baseTick (r_r.baseTick),
        .ctrl     (r_r.ctrlAz),
        .divider  (r_r.divAz),
        .suppress (r_r.cutoffEn[0] && r_r.overheat[0]),
        .pwm      (pwmAz),
        .dir      (dirAz)
    );

    // Pitch drive, using the second prescaler field.
    tamio_pwm_channel #(
        .PERIOD (PWM_PERIOD)
    ) u_pwm_pi (
        .clk      (clk),
        .reset    (reset),
        .baseTick (r_r.baseTick),
        .ctrl     (r_r.ctrlPi),
        .divider  (r_r.divPi),
        .suppress (r_r.cutoffEn[1] && r_r.overheat[1]),
        .pwm      (pwmPi),
        .dir      (dirPi)
    );

    // Address decode and read mux; unmapped addresses read as zero.
    always_comb begin
        readWord = 32'h0000_0000;
        mapped   = 1'b1;
        unique case (paddr)
            `TAMIO_OFF_REVISION: readWord[15:0] = LOGIC_REVISION;
            `TAMIO_OFF_ENC_AZ:   readWord[15:0] = encAz;
            `TAMIO_OFF_ENC_PI:   readWord[15:0] = encPi;
            `TAMIO_OFF_CLEAR:    readWord[1:0]  = r_r.clearFlags;
            `TAMIO_OFF_CTRL_AZ:  readWord[10:0] = r_r.ctrlAz;
            `TAMIO_OFF_CTRL_PI:  readWord[10:0] = r_r.ctrlPi;
            `TAMIO_OFF_DIVIDER: begin
                readWord[`TAMIO_DIV_AZ_LSB +: 6] = r_r.divAz;
                readWord[`TAMIO_DIV_PI_LSB +: 6] = r_r.divPi;
            end
            `TAMIO_OFF_OVERHEAT: readWord[1:0]  = r_r.overheat;
            `TAMIO_OFF_CUTOFF:   readWord[1:0]  = r_r.cutoffEn;
            `TAMIO_OFF_TACHO_AZ: readWord[11:0] = r_r.tachoAz;
            `TAMIO_OFF_TACHO_PI: readWord[11:0] = r_r.tachoPi;
            `TAMIO_OFF_BRAKE:    readWord[1:0]  = r_r.brake;
            default:             mapped         = 1'b0;
        endcase
    end

    // The first access cycle is always a wait state, so every output of
    // the slave can come from a flop; writes land on the completing edge.
    assign accessPh = psel && penable && !r_r.pready;
    assign doWrite  = psel && penable && r_r.pready && pwrite && !r_r.pslverr;

    // Next-state of bus, register file, base tick and sampled inputs.
    always_comb begin
        r_nxt         = r_r;
        r_nxt.pready  = accessPh;
        r_nxt.pslverr = accessPh && !mapped;
        if (accessPh) begin
            r_nxt.prdata = pwrite ? 32'h0000_0000 : readWord;
        end
        // Software writes; read-only words silently ignore the data.
        if (doWrite) begin
            unique case (paddr)
                `TAMIO_OFF_CLEAR:   r_nxt.clearFlags = pwdata[1:0];
                `TAMIO_OFF_CTRL_AZ: r_nxt.ctrlAz     = pwdata[10:0];
                `TAMIO_OFF_CTRL_PI: r_nxt.ctrlPi     = pwdata[10:0];
                `TAMIO_OFF_DIVIDER: begin
                    r_nxt.divAz = pwdata[`TAMIO_DIV_AZ_LSB +: 6];
                    r_nxt.divPi = pwdata[`TAMIO_DIV_PI_LSB +: 6];
                end
                `TAMIO_OFF_CUTOFF:  r_nxt.cutoffEn   = pwdata[1:0];
                `TAMIO_OFF_BRAKE:   r_nxt.brake      = pwdata[1:0];
                default:            r_nxt.brake      = r_r.brake;
            endcase
        end
        // Base tick divides the system clock down to 40 MHz.
        if (r_r.baseDiv == 3'(`TAMIO_BASE_DIV - 1)) begin
            r_nxt.baseDiv  = 3'h0;
            r_nxt.baseTick = 1'b1;
        end else begin
            r_nxt.baseDiv  = r_r.baseDiv + 3'h1;
            r_nxt.baseTick = 1'b0;
        end
        // Overheat levels pass through one flop before status and cutoff.
        r_nxt.overheat = overheatIn;
        // A converter result replaces the previous one on its strobe.
        if (tachoValid) begin
            r_nxt.tachoAz = tachoAzIn;
            r_nxt.tachoPi = tachoPiIn;
        end
    end

    // One clocked process registers the whole state.
    always_ff @(posedge clk) begin
        if (reset) begin
            r_r            <= '0;
            r_r.clearFlags <= `TAMIO_RST_CLEAR;
            r_r.ctrlAz     <= `TAMIO_RST_CTRL;
            r_r.ctrlPi     <= `TAMIO_RST_CTRL;
            r_r.divAz      <= `TAMIO_RST_DIV;
            r_r.divPi      <= `TAMIO_RST_DIV;
            r_r.cutoffEn   <= `TAMIO_RST_CUTOFF; // Protect amplifiers by default.
            r_r.brake      <= `TAMIO_RST_BRAKE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs taken straight from the state flops.
    assign prdata  = r_r.prdata;
    assign pready  = r_r.pready;
    assign pslverr = r_r.pslverr;
    assign brakeAz = r_r.brake[0];
    assign brakePi = r_r.brake[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Ready is a single-cycle pulse after exactly one wait state.
    a_ready_one_wait: assert property (
        (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready ##1 !pready)
        else $error("Ready did not follow one wait state.");

    // The base tick recurs every five clocks.
    a_base_tick_rate: assert property (
        r_r.baseTick |=> !r_r.baseTick [*4] ##1 r_r.baseTick)
        else $error("Base tick period is wrong.");

    // An overheated channel with cutoff enabled is low two edges later.
    a_overheat_cuts_az: assert property (
        (overheatIn[0] && r_r.cutoffEn[0]) [*2] |=> !pwmAz)
        else $error("Azimuth wave driven while overheated.");

    // Status register mirrors the amplifier level one edge later.
    a_overheat_status: assert property (
        overheatIn[1] |=> r_r.overheat[1])
        else $error("Pitch overheat status missed.");

    // Clearing azimuth alone holds the azimuth counter at zero.
    a_clear_az_only: assert property (
        (r_r.clearFlags == 2'b01) [*2] |-> encAz == 16'sh0000)
        else $error("Azimuth counter not held by its clear.");

    // Zero control on pitch keeps its wave low.
    a_zero_ctrl_idle: assert property (
        (r_r.ctrlPi == 11'sh000) [*2] |-> !pwmPi)
        else $error("Pitch wave high with zero control.");

    // A read of an unmapped word is answered with an error.
    a_unmapped_error: assert property (
        (psel && penable && !pready && !mapped) |=> pready && pslverr)
        else $error("Unmapped access not flagged.");

    // Revision word reads back the fixed code.
    a_revision_read: assert property (
        (psel && penable && !pready && !pwrite && paddr == `TAMIO_OFF_REVISION)
            |=> prdata[15:0] == LOGIC_REVISION)
        else $error("Revision code read wrong.");
endmodule : tamio_top
`default_nettype wire

// ==== dv/tamio_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tamio_motor_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset,
    // Bench commands: one encoder step per asserted cycle, amplifier heat.
    input  wire logic [1:0] stepReq,
    input  wire logic [1:0] stepDown,
    input  wire logic [1:0] hotCmd,
    // Encoder phases.
    output var  logic       encAzA,
    output var  logic       encAzB,
    output var  logic       encPiA,
    output var  logic       encPiB,
    // Amplifier overheat levels, azimuth in bit 0.
    output var  logic [1:0] overheatIn
);
    logic [1:0] phAz;
    logic [1:0] phPi;

    // Shaft positions move one quadrature state per commanded cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            phAz       <= 2'h0;
            phPi       <= 2'h0;
            overheatIn <= 2'h0;
        end else begin
            if (stepReq[0]) phAz <= stepDown[0] ? phAz - 2'h1 : phAz + 2'h1;
            if (stepReq[1]) phPi <= stepDown[1] ? phPi - 2'h1 : phPi + 2'h1;
            overheatIn <= hotCmd; // The thermal sensor lags by one cycle.
        end
    end

    // Gray sequence 00, 01, 11, 10 on (A, B) makes B lead A when stepping up,
    // which is the sense that the counter takes as counting up.
    always_comb begin
        encAzA = phAz[1];
        encAzB = phAz[0] ^ phAz[1];
        encPiA = phPi[1];
        encPiB = phPi[0] ^ phPi[1];
    end
endmodule : tamio_motor_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tamio_cfg.svh"
module testbench;
    import tamio_pkg::*;
    localparam logic [15:0] REV   = 16'h3c5a; // Arbitrary value.
    localparam int          P     = 8;
    localparam int          LIMIT = 60000;
    logic         clk, reset, psel, penable, pwrite, pready, pslverr, err, tachoValid;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         encAzA, encAzB, encPiA, encPiB;
    logic [1:0]   overheatIn, stepReq, stepDown, hotCmd;
    tamio_tacho_t tachoAzIn, tachoPiIn, tAz, tPi;
    logic         pwmAz, dirAz, brakeAz, pwmPi, dirPi, brakePi;
    logic [15:0]  expAz, expPi;
    tamio_ctrl_t  cAz, cPi;
    tamio_div_t   dAz, dPi;
    int           nMismatch, checks, hiAz, hiPi, n;
    int           cycles = 0;
    tamio_ctrl_t  cTa[4] = '{11'h000, 11'h400, 11'h003, 11'h7ff};
    tamio_ctrl_t  cTp[4] = '{11'h3ff, 11'h7f8, 11'h7fb, 11'h005};
    tamio_div_t   dTa[4] = '{6'h00, 6'h01, 6'h3f, 6'h02};
    tamio_div_t   dTp[4] = '{6'h3f, 6'h00, 6'h03, 6'h01};

    tamio_top #(.LOGIC_REVISION(REV), .PWM_PERIOD(P)) tamio_top_inst (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .encAzA(encAzA), .encAzB(encAzB), .encPiA(encPiA),
        .encPiB(encPiB), .overheatIn(overheatIn), .tachoAzIn(tachoAzIn),
        .tachoPiIn(tachoPiIn), .tachoValid(tachoValid), .pwmAz(pwmAz), .dirAz(dirAz),
        .brakeAz(brakeAz), .pwmPi(pwmPi), .dirPi(dirPi), .brakePi(brakePi));

    tamio_motor_model tamio_motor_model_inst (
        .clk(clk), .reset(reset), .stepReq(stepReq), .stepDown(stepDown),
        .hotCmd(hotCmd), .encAzA(encAzA), .encAzB(encAzB), .encPiA(encPiA),
        .encPiB(encPiB), .overheatIn(overheatIn));

    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    // A hung handshake must not stall the run forever.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            nMismatch++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen at an edge.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Wait as long as the slave needs; only the run timeout ends a hang.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rchk

    task move(input int ch, input int cnt, input logic down);
        repeat (cnt) begin
            stepReq[ch]  <= 1'b1;
            stepDown[ch] <= down;
            @(posedge clk);
        end
        stepReq[ch] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : move

    // High clocks in one period: clipped magnitude times prescaled base ticks.
    function int hiExp(input tamio_ctrl_t c, input tamio_div_t d);
        int m;
        m = (c < 0) ? -int'(c) : int'(c);
        if (m > P) m = P;
        return m * (int'(d) + 1) * `TAMIO_BASE_DIV;
    endfunction : hiExp

    // Program both channels, let them settle, then count high cycles per period.
    task pwm_run(input tamio_ctrl_t ca, input tamio_ctrl_t cp, input tamio_div_t da,
                 input tamio_div_t dp);
        int la, lp, lm;
        la = P * (int'(da) + 1) * `TAMIO_BASE_DIV;
        lp = P * (int'(dp) + 1) * `TAMIO_BASE_DIV;
        lm = (la > lp) ? la : lp;
        apb(1'b1, `TAMIO_OFF_CTRL_AZ, {21'h0, ca});
        apb(1'b1, `TAMIO_OFF_CTRL_PI, {21'h0, cp});
        apb(1'b1, `TAMIO_OFF_DIVIDER, {18'h0, dp, 2'h0, da});
        repeat (2 * lm) @(posedge clk);
        hiAz = 0;
        hiPi = 0;
        for (int i = 0; i < lm; i++) begin
            @(posedge clk);
            if (i < la && pwmAz === 1'b1) hiAz++;
            if (i < lp && pwmPi === 1'b1) hiPi++;
        end
    endtask : pwm_run

    initial begin
        clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; tachoValid = 1'b0; tachoAzIn = 12'h000;
        tachoPiIn = 12'h000; stepReq = 2'h0; stepDown = 2'h0; hotCmd = 2'h0;
        expAz = 16'h0000; expPi = 16'h0000; nMismatch = 0; checks = 0;
        void'($urandom(32'hf2d9));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // Reset state, read-only word and an unmapped address.
        rchk(`TAMIO_OFF_REVISION, {16'h0, REV}, "revision");
        rchk(`TAMIO_OFF_CUTOFF, 32'h3, "cutoff reset");
        rchk(`TAMIO_OFF_CLEAR, 32'h0, "clear reset");
        rchk(`TAMIO_OFF_DIVIDER, 32'h0, "divider reset");
        chk({28'h0, pwmAz, pwmPi, dirAz, dirPi}, 32'h0, "drive after reset");
        apb(1'b1, `TAMIO_OFF_REVISION, 32'hffffffff);
        rchk(`TAMIO_OFF_REVISION, {16'h0, REV}, "revision kept");
        apb(1'b0, 12'h030, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        // Encoders: up, then down past zero, on separate axes.
        n = $urandom_range(1, 40);
        move(0, n, 1'b0);
        expAz = expAz + 16'(n);
        rchk(`TAMIO_OFF_ENC_AZ, {16'h0, expAz}, "az up");
        rchk(`TAMIO_OFF_ENC_PI, 32'h0, "pi idle");
        n = $urandom_range(41, 80);
        move(0, n, 1'b1);
        expAz = expAz - 16'(n);
        rchk(`TAMIO_OFF_ENC_AZ, {16'h0, expAz}, "az negative");
        n = $urandom_range(1, 30);
        move(1, n, 1'b1);
        expPi = expPi - 16'(n);
        rchk(`TAMIO_OFF_ENC_PI, {16'h0, expPi}, "pi down");
        // Hold azimuth cleared while both shafts turn.
        apb(1'b1, `TAMIO_OFF_CLEAR, 32'h1);
        move(0, 5, 1'b0);
        move(1, 3, 1'b0);
        expAz = 16'h0000;
        expPi = expPi + 16'h0003;
        rchk(`TAMIO_OFF_ENC_AZ, 32'h0, "az held");
        rchk(`TAMIO_OFF_ENC_PI, {16'h0, expPi}, "pi free");
        rchk(`TAMIO_OFF_CLEAR, 32'h1, "clear flags");
        apb(1'b1, `TAMIO_OFF_CLEAR, 32'h0);
        move(0, 7, 1'b1);
        rchk(`TAMIO_OFF_ENC_AZ, {16'h0, expAz - 16'h0007}, "az resumes");
        // Duty, direction and prescaler: corner table, then random settings.
        for (int k = 0; k < 8; k++) begin
            if (k < 4) begin
                cAz = cTa[k]; cPi = cTp[k]; dAz = dTa[k]; dPi = dTp[k];
            end else begin
                cAz = 11'($urandom_range(0, 24)) - 11'h00c;
                cPi = 11'($urandom_range(0, 24)) - 11'h00c;
                dAz = 6'($urandom_range(0, 3));
                dPi = 6'($urandom_range(0, 3));
            end
            pwm_run(cAz, cPi, dAz, dPi);
            chk(hiAz, hiExp(cAz, dAz), "az duty");
            chk(hiPi, hiExp(cPi, dPi), "pi duty");
            chk({31'h0, dirAz}, {31'h0, cAz[10]}, "az direction");
            chk({31'h0, dirPi}, {31'h0, cPi[10]}, "pi direction");
        end
        // Overheat status and cutoff per channel.
        hotCmd <= 2'b01;
        repeat (4) @(posedge clk);
        rchk(`TAMIO_OFF_OVERHEAT, 32'h1, "az hot");
        pwm_run(11'h3ff, 11'h3ff, 6'h00, 6'h00);
        chk(hiAz, 0, "az cut");
        chk(hiPi, P * `TAMIO_BASE_DIV, "pi runs");
        apb(1'b1, `TAMIO_OFF_CUTOFF, 32'h2);
        pwm_run(11'h3ff, 11'h3ff, 6'h00, 6'h00);
        chk(hiAz, P * `TAMIO_BASE_DIV, "az cutoff off");
        hotCmd <= 2'b10;
        apb(1'b1, `TAMIO_OFF_CUTOFF, 32'h3);
        rchk(`TAMIO_OFF_OVERHEAT, 32'h2, "pi hot");
        pwm_run(11'h3ff, 11'h3ff, 6'h00, 6'h00);
        chk(hiPi, 0, "pi cut");
        chk(hiAz, P * `TAMIO_BASE_DIV, "az runs");
        hotCmd <= 2'b00;
        // Stop: zero control on both channels.
        pwm_run(11'h000, 11'h000, 6'h01, 6'h01);
        chk(hiAz + hiPi, 0, "stopped");
        // Converter results latch only on the valid pulse.
        tAz = 12'($urandom);
        tPi = 12'($urandom);
        tachoAzIn  <= tAz;
        tachoPiIn  <= tPi;
        tachoValid <= 1'b1;
        @(posedge clk);
        tachoValid <= 1'b0;
        tachoAzIn  <= ~tAz;
        tachoPiIn  <= ~tPi;
        rchk(`TAMIO_OFF_TACHO_AZ, {20'h0, tAz}, "tacho az");
        rchk(`TAMIO_OFF_TACHO_PI, {20'h0, tPi}, "tacho pi");
        // Every brake combination reaches the pins.
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `TAMIO_OFF_BRAKE, 32'(k));
            chk({30'h0, brakePi, brakeAz}, 32'(k), "brake pins");
        end
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
